// [design/dout_channel.sv]
// per-channel fault synchroniser and diagnostic encoder
`timescale 1ns/1ns
module dout_channel
   import dout_map_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   // fault detector pins
   input wire fault_type i_fault,
   // diagnostic results
   output logic o_flag,
   output logic [1:0] o_code
);

   fault_type sync1_reg, sync1_next;
   fault_type sync2_reg, sync2_next;
   logic flag_reg, flag_next;
   logic [1:0] code_reg, code_next;

   // two-stage synchroniser, then flag and code from the second stage
   always_comb begin
      sync1_next = i_fault;
      sync2_next = sync1_reg;
      flag_next = sync2_reg.overload | sync2_reg.short_circuit | sync2_reg.open_wire; // [RQ5] [RQ13]
      if (sync2_reg.short_circuit) begin
         code_next = DIAG_CODE_SHORT; // [RQ8]
      end else if (sync2_reg.overload) begin
         code_next = DIAG_CODE_OVERLOAD;
      end else if (sync2_reg.open_wire) begin
         code_next = DIAG_CODE_OPEN;
      end else begin
         code_next = DIAG_CODE_NONE;
      end
   end

   // registers
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         flag_reg <= 1'h0;
         code_reg <= DIAG_CODE_NONE;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         flag_reg <= flag_next;
         code_reg <= code_next;
      end
   end

   assign o_flag = flag_reg;
   assign o_code = code_reg;

endmodule

// [design/dout_image_mapper.sv]
// digital output image mapper: image store, channel drive, diagnostics and interrupt
`timescale 1ns/1ns
module dout_image_mapper
   import dout_map_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   // register port
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   // fault detectors and manual-operation switch
   input wire fault_type [NUM_CH-1:0] i_fault,
   input wire logic i_manual_op,
   // output drivers and interrupt
   output logic [NUM_CH-1:0] o_dout,
   output logic o_irq
);

   // register map, byte addresses, data in the low bits, upper bits read as zero
   //   0x00 control: layout code in bits 2:0, analog word count in bits 6:4
   //   0x04 fault status: one sticky bit per channel, write one to clear
   //   0x08 fault mask: one enable bit per channel
   //   0x0c input image byte, read only
   //   0x10 output state: drive pins in bits 7:0, primed in bit 8, read only
   //   0x40 + 4*k: output image byte k, k from 0 to 15
   // layout codes
   //   0 one channel with manual-operation status
   //   1 two channels
   //   2 two channels, one fault flag each
   //   3 two channels, two-bit fault code each
   //   4 four channels
   //   5 four channels, one fault flag each
   //   6 eight channels
   //   7 no channel driven
   // analog words take image bytes 0 to 2n-1, so the digital byte sits at 2n
   // writing control drops primed, so the pins stay off until that byte is written
   // image writes to other indices are stored and read back but steer nothing
   // a two-bit code reads 0 none, 1 overload, 2 short circuit, 3 broken wire
   // fault events only count in layouts with diagnostics, and only while primed
   // the interrupt pin follows status and mask one clock later
   // read data stand for one clock after the strobe and read zero otherwise

   // output bits that steer a channel in each layout
   function automatic logic [7:0] out_mask(input layout_type lay);
      logic [7:0] m;
      m = 8'h00;
      case (lay)
         LAYOUT_ONE_CH_STATUS: m = 8'h01; // [RQ3]
         LAYOUT_TWO_CH: m = 8'h03; // [RQ4]
         LAYOUT_TWO_CH_DIAG: m = 8'h03; // [RQ7]
         LAYOUT_TWO_CH_DIAG2: m = 8'h03; // [RQ10]
         LAYOUT_FOUR_CH: m = 8'h0f; // [RQ11]
         LAYOUT_FOUR_CH_DIAG: m = 8'h0f; // [RQ12]
         LAYOUT_EIGHT_CH: m = 8'hff; // [RQ14]
         default: m = 8'h00;
      endcase
      return m;
   endfunction

   // channels whose faults are reported in each layout
   function automatic logic [7:0] diag_mask(input layout_type lay);
      logic [7:0] m;
      m = 8'h00;
      case (lay)
         LAYOUT_TWO_CH_DIAG: m = 8'h03;
         LAYOUT_TWO_CH_DIAG2: m = 8'h03;
         LAYOUT_FOUR_CH_DIAG: m = 8'h0f;
         default: m = 8'h00;
      endcase
      return m;
   endfunction

   // input image byte for each layout, unused bits zero
   function automatic logic [7:0] in_pack(input layout_type lay, input logic [7:0] flags,
                                          input logic [3:0] codes, input logic manual);
      logic [7:0] b;
      b = 8'h00; // [RQ15]
      case (lay)
         LAYOUT_ONE_CH_STATUS: b = {7'h00, manual}; // [RQ3]
         LAYOUT_TWO_CH: b = 8'h00; // [RQ4]
         LAYOUT_TWO_CH_DIAG: b = {6'h00, flags[1:0]}; // [RQ6] [RQ7] [RQ13]
         LAYOUT_TWO_CH_DIAG2: b = {4'h0, codes}; // [RQ8]
         LAYOUT_FOUR_CH: b = 8'h00;
         LAYOUT_FOUR_CH_DIAG: b = {4'h0, flags[3:0]}; // [RQ12] [RQ13]
         default: b = 8'h00;
      endcase
      return b;
   endfunction

   // configuration and image state
   logic [CTRL_LAYOUT_W-1:0] layout_reg, layout_next;
   logic [CTRL_ANALOG_W-1:0] analog_reg, analog_next;
   logic [7:0] img_reg [IMG_DEPTH];
   logic [7:0] img_next [IMG_DEPTH];
   logic primed_reg, primed_next;
   logic [NUM_CH-1:0] dout_reg, dout_next;

   // interrupt state
   logic [NUM_CH-1:0] irq_status_reg, irq_status_next;
   logic [NUM_CH-1:0] irq_mask_reg, irq_mask_next;
   logic [NUM_CH-1:0] flag_prev_reg, flag_prev_next;
   logic irq_reg, irq_next;

   // read port and manual-switch synchroniser
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic manual_s1_reg, manual_s1_next;
   logic manual_s2_reg, manual_s2_next;

   // decoded views
   layout_type layout;
   logic [IMG_IDX_W-1:0] img_idx;
   logic [IMG_IDX_W-1:0] digital_idx;
   logic img_hit;
   logic [NUM_CH-1:0] ch_flag;
   logic [1:0] ch_code [NUM_CH];
   logic [7:0] in_image;
   logic [NUM_CH-1:0] fault_event;

   // per-channel fault synchronisers and encoders
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : gen_ch
         dout_channel u_channel (
            .i_sys_clk(i_sys_clk),
            .i_resetn(i_resetn),
            .i_fault(i_fault[g]),
            .o_flag(ch_flag[g]),
            .o_code(ch_code[g])
         );
      end
   endgenerate

   // address decode and image placement
   always_comb begin
      layout = layout_type'(layout_reg);
      img_idx = i_addr[IMG_IDX_W+1:2];
      img_hit = (i_addr[7:6] == IMG_AREA_TAG) && (i_addr[1:0] == 2'h0);
      digital_idx = {analog_reg, 1'h0}; // [RQ2]
   end

   // input image, held clear until the first output image arrives
   always_comb begin
      if (primed_reg) begin
         in_image = in_pack(layout, ch_flag, {ch_code[1], ch_code[0]}, manual_s2_reg); // [RQ6]
      end else begin
         in_image = 8'h00; // [RQ16]
      end
      // a fault event is a flag that was low one clock before
      fault_event = ch_flag & ~flag_prev_reg & diag_mask(layout) & {NUM_CH{primed_reg}};
   end

   // configuration, image store and channel drive
   always_comb begin
      layout_next = layout_reg;
      analog_next = analog_reg;
      primed_next = primed_reg;
      for (int i = 0; i < IMG_DEPTH; i++) begin
         img_next[i] = img_reg[i];
      end
      if (i_wr && (i_addr == REG_CTRL)) begin
         layout_next = i_wdata[CTRL_LAYOUT_LSB +: CTRL_LAYOUT_W];
         analog_next = i_wdata[CTRL_ANALOG_LSB +: CTRL_ANALOG_W];
         primed_next = 1'h0; // outputs off until an image of the new layout arrives
      end else if (i_wr && img_hit) begin
         img_next[img_idx] = i_wdata[7:0];
         if (img_idx == digital_idx) begin
            primed_next = 1'h1; // [RQ16]
         end
      end
   end

   // channel drive from the digital byte, off until primed
   always_comb begin
      if (primed_reg) begin
         dout_next = img_reg[digital_idx] & out_mask(layout); // [RQ1] [RQ2] [RQ15]
      end else begin
         dout_next = BYTE_RESET; // [RQ16]
      end
   end

   // sticky fault status, mask and interrupt level
   always_comb begin
      irq_status_next = irq_status_reg;
      irq_mask_next = irq_mask_reg;
      if (i_wr && (i_addr == REG_IRQ_STATUS)) begin
         irq_status_next = irq_status_reg & ~i_wdata[NUM_CH-1:0];
      end
      irq_status_next = irq_status_next | fault_event; // set wins over clear
      if (i_wr && (i_addr == REG_IRQ_MASK)) begin
         irq_mask_next = i_wdata[NUM_CH-1:0];
      end
      flag_prev_next = ch_flag;
      irq_next = |(irq_status_reg & irq_mask_reg);
   end

   // read data, valid only in the cycle after the strobe
   always_comb begin
      rdata_next = '0;
      if (i_rd) begin
         if (img_hit) begin
            rdata_next = {24'h000000, img_reg[img_idx]};
         end else begin
            case (i_addr)
               REG_CTRL: begin
                  rdata_next[CTRL_LAYOUT_LSB +: CTRL_LAYOUT_W] = layout_reg;
                  rdata_next[CTRL_ANALOG_LSB +: CTRL_ANALOG_W] = analog_reg;
               end
               REG_IRQ_STATUS: rdata_next[NUM_CH-1:0] = irq_status_reg;
               REG_IRQ_MASK: rdata_next[NUM_CH-1:0] = irq_mask_reg;
               REG_IN_IMAGE: rdata_next[7:0] = in_image;
               REG_OUT_STATE: begin
                  rdata_next[NUM_CH-1:0] = dout_reg;
                  rdata_next[OUT_STATE_PRIMED_BIT] = primed_reg;
               end
               default: rdata_next = '0; // unmapped reads as zero
            endcase
         end
      end
   end

   // manual-operation switch synchroniser
   always_comb begin
      manual_s1_next = i_manual_op;
      manual_s2_next = manual_s1_reg;
   end

   // configuration and image registers
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         layout_reg <= LAYOUT_RESET;
         analog_reg <= ANALOG_RESET;
         primed_reg <= 1'h0;
         for (int i = 0; i < IMG_DEPTH; i++) begin
            img_reg[i] <= BYTE_RESET;
         end
      end else begin
         layout_reg <= layout_next;
         analog_reg <= analog_next;
         primed_reg <= primed_next;
         for (int i = 0; i < IMG_DEPTH; i++) begin
            img_reg[i] <= img_next[i];
         end
      end
   end

   // channel drive register
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         dout_reg <= BYTE_RESET;
      end else begin
         dout_reg <= dout_next;
      end
   end

   // fault status, mask, edge memory and interrupt registers
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         irq_status_reg <= '0;
         irq_mask_reg <= '0;
         flag_prev_reg <= '0;
         irq_reg <= 1'h0;
      end else begin
         irq_status_reg <= irq_status_next;
         irq_mask_reg <= irq_mask_next;
         flag_prev_reg <= flag_prev_next;
         irq_reg <= irq_next;
      end
   end

   // read data register
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // manual-operation synchroniser registers
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         manual_s1_reg <= 1'h0;
         manual_s2_reg <= 1'h0;
      end else begin
         manual_s1_reg <= manual_s1_next;
         manual_s2_reg <= manual_s2_next;
      end
   end

   // outputs straight from flip-flops
   assign o_dout = dout_reg;
   assign o_irq = irq_reg;
   assign o_rdata = rdata_reg;

endmodule

// [design/dout_map_pkg.sv]
// constants, types and register map of the digital output image mapper
// Notes on behaviour
// (RQ1) Every output channel owns one output image bit whose value sets that channel's output.
// (RQ2) With analog words present, the digital byte sits after all analog words in the image.
// (RQ3) One-channel layout: bit 0 drives the channel, bit 1 is ignored, input bit 0 is manual.
// (RQ4) Plain two-channel layout: bits 0 and 1 drive channels 1 and 2, no input bits used.
// (RQ5) Diagnostic layouts raise a channel flag on overload, short circuit or broken wire.
// (RQ6) Diagnostic layouts put flags in the input image and controls in the output image.
// (RQ7) Two-channel diagnostic layout: input bits 0 and 1 carry the faults of channels 1 and 2.
// (RQ8) Two-bit diagnostic layout: bits 1:0 belong to channel 1 and bits 3:2 to channel 2.
// (RQ9) The reader of the two-bit layout decodes each two-bit code into the fault kind.
// (RQ10) Two-bit diagnostic layout: output bits 0 and 1 drive, bits 2 and 3 change nothing.
// (RQ11) Plain four-channel layout: bits 0 to 3 drive channels 1 to 4, bits 4 to 7 unused.
// (RQ12) Four-channel diagnostic layout: input bits 0 to 3 carry faults of channels 1 to 4.
// (RQ13) A one-bit flag reads 0 with no error and 1 on overload, short circuit or broken wire.
// (RQ14) Eight-channel layout: output bits 0 to 7 drive channels 1 to 8.
// (RQ15) Unused image bits are ignored on output and read back as zero on input.
// (RQ16) After reset all outputs are off and flags clear until the first output image arrives.
package dout_map_pkg;

   // bus and image geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NUM_CH = 8;
   localparam int IMG_DEPTH = 16;
   localparam int IMG_IDX_W = 4;

   // register byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_MASK = 8'h08;
   localparam logic [7:0] REG_IN_IMAGE = 8'h0c;
   localparam logic [7:0] REG_OUT_STATE = 8'h10;
   localparam logic [1:0] IMG_AREA_TAG = 2'h1;

   // control register fields
   localparam int CTRL_LAYOUT_LSB = 0;
   localparam int CTRL_LAYOUT_W = 3;
   localparam int CTRL_ANALOG_LSB = 4;
   localparam int CTRL_ANALOG_W = 3;
   localparam int OUT_STATE_PRIMED_BIT = 8;

   // reset values
   localparam logic [2:0] LAYOUT_RESET = 3'h0;
   localparam logic [2:0] ANALOG_RESET = 3'h0;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // two-bit diagnostic codes
   localparam logic [1:0] DIAG_CODE_NONE = 2'h0;
   localparam logic [1:0] DIAG_CODE_OVERLOAD = 2'h1;
   localparam logic [1:0] DIAG_CODE_SHORT = 2'h2;
   localparam logic [1:0] DIAG_CODE_OPEN = 2'h3;

   // module layouts
   typedef enum logic [2:0] {
      LAYOUT_ONE_CH_STATUS,
      LAYOUT_TWO_CH,
      LAYOUT_TWO_CH_DIAG,
      LAYOUT_TWO_CH_DIAG2,
      LAYOUT_FOUR_CH,
      LAYOUT_FOUR_CH_DIAG,
      LAYOUT_EIGHT_CH
   } layout_type;

   // fault detector lines of one channel
   typedef struct packed {
      logic overload;
      logic short_circuit;
      logic open_wire;
   } fault_type;

endpackage

// [dv/digital_output_image_mapper_tb_top.sv]
// self-checking bench of the digital output image mapper
`timescale 1ns/1ns
module digital_output_image_mapper_tb_top
   import dout_map_pkg::*;
;
   logic clk, resetn = 1'h0, wr = 1'h0, rd = 1'h0, manual = 1'h0, fgo = 1'h0, irq;
   logic [7:0] addr = 8'h00, dout;
   logic [31:0] wdata = 32'h0, rdata;
   logic [2:0] fch = 3'h0;
   fault_type fkind = 3'h0;
   fault_type [NUM_CH-1:0] fault;
   int fail_count = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [7:0] omask [8] = '{8'h01, 8'h03, 8'h03, 8'h03, 8'h0f, 8'h0f, 8'hff, 8'h00};
   dout_image_mapper DUT (
      .i_sys_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .i_fault(fault), .i_manual_op(manual),
      .o_dout(dout), .o_irq(irq)
   );
   dout_fault_src far (
      .i_sys_clk(clk), .i_resetn(resetn), .i_go(fgo), .i_ch(fch), .i_kind(fkind),
      .o_fault(fault)
   );
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // bus write, one strobe cycle and one gap
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
      @(posedge clk);
   endtask
   // bus read, data judged in the cycle after the strobe
   task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1;
      chk(rdata, exp);
      @(posedge clk);
   endtask
   task automatic ctrl(input logic [2:0] l, input logic [2:0] n);
      bus_wr(REG_CTRL, {25'h0, n, 1'h0, l});
   endtask
   task automatic img(input logic [3:0] k, input logic [7:0] b);
      bus_wr({IMG_AREA_TAG, k, 2'h0}, {24'h0, b});
   endtask
   task automatic flt(input logic [2:0] c, input fault_type k);
      fgo <= 1'h1;
      fch <= c;
      fkind <= k;
      @(posedge clk);
      fgo <= 1'h0;
      @(posedge clk);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // judge drive pins and interrupt once settled
   task automatic pins(input logic [7:0] d, input logic q);
      #1;
      chk({24'h0, dout}, {24'h0, d});
      chk({31'h0, irq}, {31'h0, q});
      @(posedge clk);
   endtask
   task automatic s_reset();
      pins(8'h00, 1'h0);
      bus_rd(REG_CTRL, 32'h0);
      bus_rd(REG_IRQ_MASK, 32'h0);
      bus_rd(REG_OUT_STATE, 32'h0);
      bus_rd(REG_IN_IMAGE, 32'h0);
   endtask
   task automatic s_layouts();
      manual <= 1'h1;
      for (int l = 0; l < 8; l++) begin
         ctrl(3'(l), 3'(l % 3));
         img(4'h0, 8'h5a);
         pins((l % 3 == 0) ? omask[l] & 8'h5a : 8'h00, 1'h0);
         img(4'(2 * (l % 3)), 8'hff);
         pins(omask[l], 1'h0);
         img(4'(2 * (l % 3)), 8'ha6);
         pins(omask[l] & 8'ha6, 1'h0);
         bus_rd(REG_OUT_STATE, {23'h0, 1'h1, omask[l] & 8'ha6});
         bus_rd(REG_IN_IMAGE, {31'h0, l == 0});
      end
      manual <= 1'h0;
   endtask
   task automatic s_diag();
      for (int i = 0; i < 3; i++) begin
         flt(3'h1, 3'(4 >> i));
         flt(3'h3, 3'(4 >> i));
         ctrl(LAYOUT_TWO_CH_DIAG, 3'h0);
         img(4'h0, 8'h03);
         bus_rd(REG_IN_IMAGE, 32'h2);
         ctrl(LAYOUT_FOUR_CH_DIAG, 3'h0);
         img(4'h0, 8'h0f);
         bus_rd(REG_IN_IMAGE, 32'ha);
         ctrl(LAYOUT_TWO_CH_DIAG2, 3'h0);
         img(4'h0, 8'h0f);
         pins(8'h03, 1'h0);
         bus_rd(REG_IN_IMAGE, {28'h0, 2'(i + 1), 2'h0});
      end
      flt(3'h1, 3'h0);
      flt(3'h3, 3'h0);
      idle(4);
      bus_rd(REG_IN_IMAGE, 32'h0);
   endtask
   task automatic s_irq();
      ctrl(LAYOUT_FOUR_CH_DIAG, 3'h1);
      bus_rd(REG_CTRL, 32'h15);
      img(4'h2, 8'h0f);
      bus_wr(REG_IRQ_STATUS, 32'hff);
      bus_rd(REG_IRQ_STATUS, 32'h0);
      flt(3'h0, 3'h2);
      idle(4);
      bus_rd(REG_IRQ_STATUS, 32'h1);
      pins(8'h0f, 1'h0);
      bus_wr(REG_IRQ_MASK, 32'h1);
      pins(8'h0f, 1'h1);
      bus_rd(REG_IRQ_MASK, 32'h1);
      bus_wr(REG_IRQ_STATUS, 32'h1);
      pins(8'h0f, 1'h0);
      bus_rd(REG_IRQ_STATUS, 32'h0);
      bus_wr(8'h3c, 32'hff);
      bus_wr(REG_IN_IMAGE, 32'hff);
      bus_rd(8'h3c, 32'h0);
      flt(3'h0, 3'h0);
      idle(8);
      bus_rd(REG_IN_IMAGE, 32'h0);
   endtask
   // verdict and end of run
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // 125 MHz clock
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fail_count++;
         close_out();
      end
   end
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1'h1;
      @(posedge clk);
      s_reset();
      s_layouts();
      s_diag();
      s_irq();
      close_out();
   end
endmodule

// [dv/dout_fault_src.sv]
// fault detector model standing behind the output drivers
`timescale 1ns/1ns
module dout_fault_src
   import dout_map_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   // command from the bench
   input wire logic i_go,
   input wire logic [2:0] i_ch,
   input wire fault_type i_kind,
   // detector lines towards the mapper
   output fault_type [NUM_CH-1:0] o_fault
);
   // each detector holds its fault lines until told otherwise
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_fault <= '0;
      end else if (i_go) begin
         o_fault[i_ch] <= i_kind;
      end
   end
endmodule

// [dv/dout_image_mapper_sva.sv]
// port checker of the digital output image mapper
`timescale 1ns/1ns
module dout_image_mapper_sva
   import dout_map_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   // register port
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [DATA_W-1:0] o_rdata,
   // field side
   input wire fault_type [NUM_CH-1:0] i_fault,
   input wire logic i_manual_op,
   input wire logic [NUM_CH-1:0] o_dout,
   input wire logic o_irq
);
   logic [2:0] lay_reg;
   logic [2:0] ana_reg;
   logic [7:0] msk_reg;
   logic [2:0] quiet_reg;
   logic ctrl_wr;
   logic dig_wr;
   logic in_rd;
   // channels driven per layout
   function automatic logic [7:0] out_msk(input logic [2:0] l);
      case (l)
         3'h0: return 8'h01;
         3'h1, 3'h2, 3'h3: return 8'h03;
         3'h4, 3'h5: return 8'h0f;
         3'h6: return 8'hff;
         default: return 8'h00;
      endcase
   endfunction
   // input image bits in use per layout
   function automatic logic [7:0] in_msk(input logic [2:0] l);
      case (l)
         3'h0: return 8'h01;
         3'h2: return 8'h03;
         3'h3, 3'h5: return 8'h0f;
         default: return 8'h00;
      endcase
   endfunction
   // decoded strobes
   assign ctrl_wr = i_wr && i_addr == REG_CTRL;
   assign dig_wr = i_wr && i_addr == {IMG_AREA_TAG, ana_reg, 3'h0};
   assign in_rd = i_rd && i_addr == REG_IN_IMAGE;
   // shadows of control and mask, and cycles without any fault line
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         lay_reg <= 3'h0;
         ana_reg <= 3'h0;
         msk_reg <= 8'h00;
         quiet_reg <= 3'h0;
      end else begin
         lay_reg <= ctrl_wr ? i_wdata[2:0] : lay_reg;
         ana_reg <= ctrl_wr ? i_wdata[6:4] : ana_reg;
         msk_reg <= (i_wr && i_addr == REG_IRQ_MASK) ? i_wdata[7:0] : msk_reg;
         quiet_reg <= (|i_fault) ? 3'h0 : quiet_reg + {2'h0, quiet_reg != 3'h7};
      end
   end
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_resetn);
   reset_off_a: assert property (
      $rose(i_resetn) |-> ##1 (o_dout == 8'h00 && !o_irq)) else $error("outputs on after reset");
   rd_idle_a: assert property (
      !$past(i_rd) |-> o_rdata == 32'h0) else $error("read data without read");
   unused_off_a: assert property (
      $stable(lay_reg) && $past(lay_reg, 2) == lay_reg |-> (o_dout & ~out_msk(lay_reg)) == 8'h00)
      else $error("unused channel driven");
   ctrl_clear_a: assert property (
      ctrl_wr ##1 !i_wr |-> ##1 o_dout == 8'h00) else $error("outputs kept after control write");
   dig_drive_a: assert property (
      dig_wr ##1 !i_wr |-> ##1
      {24'h0, o_dout} == ($past(i_wdata, 2) & {24'h0, out_msk(lay_reg)}))
      else $error("outputs differ from digital byte");
   in_unused_a: assert property (
      in_rd |=> (o_rdata & ~{24'h0, in_msk(lay_reg)}) == 32'h0) else $error("unused input bit set");
   no_fault_a: assert property (
      in_rd && quiet_reg == 3'h7 && (lay_reg == 3'h2 || lay_reg == 3'h5) |=> o_rdata == 32'h0)
      else $error("flag set without fault");
   irq_masked_a: assert property (
      msk_reg == 8'h00 && $past(msk_reg) == 8'h00 |-> !o_irq) else $error("masked interrupt");
   cover property (dig_wr);
   cover property (in_rd && lay_reg == 3'h3);
   cover property ($rose(o_irq));
endmodule
bind dout_image_mapper dout_image_mapper_sva chk (
   .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_fault(i_fault),
   .i_manual_op(i_manual_op), .o_dout(o_dout), .o_irq(o_irq)
);
